// file: core/dmarq_arbiter.sv
// Four-channel DMA request flags, fixed-priority arbiter and AXI4-Lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dmarq_regs.svh"
module dmarq_arbiter #(
    parameter int NCH = 4,
    parameter int NPERIPH = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Bus clock falling-edge sample strike, one cycle
    input wire logic bclkFall,
    // Request sources
    input wire logic [NPERIPH-1:0] periphIrq,
    input wire logic [NCH-1:0] externalRequestPin,
    // Transfer engine and CPU bus handshake
    output logic [NCH-1:0] xferGrant,
    output logic busToDma,
    input wire logic unitDone,
    input wire logic cpuAccessDone,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ==========================================================
    // Registers
    logic [7:0] requestSourceSelect_reg [NCH];
    logic [7:0] channelModeControl_reg;
    logic [NCH-1:0] countZero_reg;
    logic [NCH-1:0] pinLast_reg;
    logic [NCH-1:0] pending_reg;
    logic [NCH-1:0] pending_next;
    dmarq_pkg::dmarq_state_t state_reg;
    logic [NCH-1:0] grant_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic awHave_reg;
    logic wHave_reg;
    logic [NCH-1:0] chanEnabled;
    logic [NCH-1:0] chanRequest;
    logic [NCH-1:0] swSetFlag;
    logic [NCH-1:0] winner;
    logic doWrite;
    logic decodeOk;

    function automatic logic [NCH-1:0] pickFirst(input logic [NCH-1:0] v);
        logic [NCH-1:0] r;
        r = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic [1:0] chanMode(input logic [7:0] m, input int ch);
        return m[2*ch +: 2];
    endfunction

    // ==========================================================
    // Request source decode, per channel
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            logic [7:0] sel;
            logic pin;
            logic pinEdge;
            sel = requestSourceSelect_reg[c];
            pin = externalRequestPin[c];
            // Falling edge always counts; rising edge only in both-edge mode
            pinEdge = (pinLast_reg[c] & ~pin) |
                      (sel[`DMARQ_SEL_PINEDGE] & ~pinLast_reg[c] & pin);
            // Mode 10 is reserved and accepts no request
            chanEnabled[c] = ((chanMode(channelModeControl_reg, c) == `DMARQ_MODE_SINGLE) ||
                              (chanMode(channelModeControl_reg, c) == `DMARQ_MODE_REPEAT)) &&
                             !countZero_reg[c];
            if (sel[`DMARQ_SEL_SRC_HI:`DMARQ_SEL_SRC_LO] == `DMARQ_SRC_PIN) begin
                chanRequest[c] = bclkFall & pinEdge;
            end else begin
                chanRequest[c] = bclkFall &
                    periphIrq[sel[`DMARQ_SEL_SRC_HI:`DMARQ_SEL_SRC_LO]];
            end
        end
    end

    // ==========================================================
    // AXI4-Lite write side
    assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
    assign s_axi_wready = !wHave_reg && !s_axi_bvalid;
    assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
    assign decodeOk = (awAddr_reg <= `DMARQ_CNTZ_OFS) && (awAddr_reg[1:0] == 2'h0);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg <= 32'h00000000;
            wStrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DMARQ_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHave_reg <= 1'b0;
                wHave_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= decodeOk ? `DMARQ_RESP_OKAY : `DMARQ_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Select and mode registers; a flag write of zero is ignored, clearing is automatic
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < NCH; c++) begin
                requestSourceSelect_reg[c] <= `DMARQ_SEL_RST;
            end
            channelModeControl_reg <= `DMARQ_MODE_RST;
            countZero_reg <= '0;
        end else if (doWrite && wStrb_reg[0]) begin
            if (awAddr_reg == `DMARQ_MODE_OFS) begin
                channelModeControl_reg <= wData_reg[7:0];
            end else if (awAddr_reg == `DMARQ_CNTZ_OFS) begin
                countZero_reg <= wData_reg[NCH-1:0];
            end else if (awAddr_reg < `DMARQ_MODE_OFS && awAddr_reg[1:0] == 2'h0) begin
                requestSourceSelect_reg[awAddr_reg[3:2]] <= wData_reg[7:0];
            end
        end
    end

    // Software flag set: flag bit written as one sets it only when the software trigger bit is also one
    always_comb begin
        swSetFlag = '0;
        if (doWrite && wStrb_reg[0] && awAddr_reg < `DMARQ_MODE_OFS &&
            awAddr_reg[1:0] == 2'h0 && wData_reg[`DMARQ_SEL_FLAG] &&
            wData_reg[`DMARQ_SEL_SWTRIG]) begin
            swSetFlag[awAddr_reg[3:2]] = 1'b1;
        end
    end

    // ==========================================================
    // Request flags
    assign winner = pickFirst(pending_reg & chanEnabled);

    always_comb begin
        pending_next = pending_reg;
        if (state_reg == dmarq_pkg::DMARQ_IDLE ||
            (state_reg == dmarq_pkg::DMARQ_CPU && cpuAccessDone)) begin
            pending_next = pending_next & ~winner;
        end
        // A request landing with the grant is set after the clear, so it is not lost
        pending_next = pending_next | chanRequest | swSetFlag;
        // Disabled channel drops its flag rather than holding a stale request
        pending_next = pending_next & chanEnabled;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pending_reg <= '0;
            pinLast_reg <= '0;
        end else begin
            pending_reg <= pending_next;
            if (bclkFall) begin
                pinLast_reg <= externalRequestPin;
            end
        end
    end

    // ==========================================================
    // Bus ownership sequencer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= dmarq_pkg::DMARQ_IDLE;
            grant_reg <= '0;
        end else begin
            case (state_reg)
                dmarq_pkg::DMARQ_IDLE: begin
                    if (|winner) begin
                        grant_reg <= winner;
                        state_reg <= dmarq_pkg::DMARQ_XFER;
                    end
                end
                dmarq_pkg::DMARQ_XFER: begin
                    if (unitDone) begin
                        grant_reg <= '0;
                        state_reg <= dmarq_pkg::DMARQ_CPU;
                    end
                end
                dmarq_pkg::DMARQ_CPU: begin
                    if (cpuAccessDone) begin
                        if (|winner) begin
                            grant_reg <= winner;
                            state_reg <= dmarq_pkg::DMARQ_XFER;
                        end else begin
                            state_reg <= dmarq_pkg::DMARQ_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= dmarq_pkg::DMARQ_IDLE;
                end
            endcase
        end
    end

    assign xferGrant = grant_reg;
    assign busToDma = (state_reg == dmarq_pkg::DMARQ_XFER);

    // ==========================================================
    // AXI4-Lite read side
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DMARQ_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `DMARQ_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr[1:0] != 2'h0) begin
                s_axi_rresp <= `DMARQ_RESP_SLVERR;
            end else if (s_axi_araddr < `DMARQ_MODE_OFS) begin
                s_axi_rdata <= {24'h000000, pending_reg[s_axi_araddr[3:2]],
                                requestSourceSelect_reg[s_axi_araddr[3:2]][6:0]};
            end else if (s_axi_araddr == `DMARQ_MODE_OFS) begin
                s_axi_rdata <= {24'h000000, channelModeControl_reg};
            end else if (s_axi_araddr == `DMARQ_CNTZ_OFS) begin
                s_axi_rdata <= {28'h0000000, countZero_reg};
            end else if (s_axi_araddr == `DMARQ_STAT_OFS) begin
                s_axi_rdata <= {23'h000000, busToDma, grant_reg, pending_reg};
            end else begin
                s_axi_rresp <= `DMARQ_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // dmarq_arbiter

// file: include/dmarq_regs.svh
// Register offsets, field positions and reset values of the DMA request arbiter
// Function
// - Internal source sets flag with interrupt request
// - Clear flag at transfer start or disable
// - Disabled or zero-count request is dropped, cleared
// - Pin source sets on falling or both edges
// - Sample requests once per bus period
// - Fixed priority, channel 0 highest
// - Return bus to CPU after each unit
// - After one CPU access, serve next channel
// - Flag accepted only in mode 01 or 11
`ifndef DMARQ_REGS_SVH
`define DMARQ_REGS_SVH
// ==========================================================
// Register byte offsets (one word per channel for select)
`define DMARQ_SEL0_OFS 8'h00
`define DMARQ_SEL1_OFS 8'h04
`define DMARQ_SEL2_OFS 8'h08
`define DMARQ_SEL3_OFS 8'h0C
`define DMARQ_MODE_OFS 8'h10
`define DMARQ_CNTZ_OFS 8'h14
`define DMARQ_STAT_OFS 8'h18
// ==========================================================
// Source select field layout
`define DMARQ_SEL_SRC_LO 0
`define DMARQ_SEL_SRC_HI 4
`define DMARQ_SEL_PINEDGE 5
`define DMARQ_SEL_SWTRIG 6
`define DMARQ_SEL_FLAG 7
// Source code that selects the external pin; codes 1..31 pick peripheral lines
`define DMARQ_SRC_PIN 5'h00
`define DMARQ_SEL_RST 8'h00
`define DMARQ_MODE_RST 8'h00
`define DMARQ_MODE_OFF 2'h0
`define DMARQ_MODE_SINGLE 2'h1
`define DMARQ_MODE_REPEAT 2'h3
`define DMARQ_RESP_OKAY 2'h0
`define DMARQ_RESP_SLVERR 2'h2
`endif

// file: include/dmarq_pkg.sv
// Types shared by the DMA request arbiter
package dmarq_pkg;
    typedef enum logic [1:0] {
        DMARQ_IDLE,
        DMARQ_XFER,
        DMARQ_CPU
    } dmarq_state_t;
endpackage

// file: tb/dmarq_arbiter_checker.sv
// Concurrent checks on the DMA request arbiter ports
`timescale 1ns/1ps
module dmarq_arbiter_checker #(
    parameter int NCH = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Grant and bus hand-back
    input wire logic [NCH-1:0] xferGrant,
    input wire logic busToDma,
    input wire logic unitDone,
    input wire logic cpuAccessDone,
    // AXI4-Lite answers
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic cpuPhase_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // CPU owns the bus from a finished unit until its access is done
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cpuPhase_reg <= 1'b0;
        end else if (busToDma && unitDone) begin
            cpuPhase_reg <= 1'b1;
        end else if (cpuAccessDone) begin
            cpuPhase_reg <= 1'b0;
        end
    end
    sequence unitFin;
        busToDma && unitDone;
    endsequence
    sequence unitHeld;
        busToDma && !unitDone;
    endsequence
    // ==========================================================
    // Assertions
    chk_grant_onehot: assert property ($onehot0(xferGrant))
        else $error("more than one channel granted");
    chk_bus_owner: assert property (busToDma |-> $onehot(xferGrant))
        else $error("bus held with no single grant");
    chk_unit_release: assert property (unitFin |=> !busToDma)
        else $error("bus kept after a finished unit");
    chk_cpu_between: assert property (cpuPhase_reg |-> !busToDma)
        else $error("unit started before the CPU access ended");
    chk_grant_hold: assert property (unitHeld |=> $stable(xferGrant) && busToDma)
        else $error("grant changed during a unit");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response kept after its handshake");
    chk_rdata_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data kept after its handshake");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken while a response waits");
endmodule // dmarq_arbiter_checker

bind dmarq_arbiter dmarq_arbiter_checker #(.NCH(NCH)) dmarq_arbiter_checker_i (
    .core_clk(core_clk), .rstn(rstn), .xferGrant(xferGrant), .busToDma(busToDma),
    .unitDone(unitDone), .cpuAccessDone(cpuAccessDone), .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// file: tb/dmarq_bus_model.sv
// Transfer engine and CPU bus partner with a bus-clock falling-edge strike
`timescale 1ns/1ps
module dmarq_bus_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Bus handshake
    input wire logic busToDma,
    output logic bclkFall,
    output logic unitDone,
    output logic cpuAccessDone
);
    logic [1:0] div_reg;
    logic [2:0] cnt_reg;
    logic slow_reg;
    logic cpuPend_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div_reg <= 2'h0;
            bclkFall <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            bclkFall <= (div_reg == 2'h3);
        end
    end
    // Units alternate between a prompt and a slow finish
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {cnt_reg, slow_reg, cpuPend_reg, unitDone, cpuAccessDone} <= '0;
        end else begin
            unitDone <= 1'b0;
            cpuAccessDone <= 1'b0;
            if (busToDma && !unitDone) begin
                cnt_reg <= cnt_reg + 3'h1;
                if (cnt_reg == (slow_reg ? 3'h3 : 3'h0)) begin
                    unitDone <= 1'b1;
                    cnt_reg <= 3'h0;
                    slow_reg <= !slow_reg;
                    cpuPend_reg <= 1'b1;
                end
            end else if (cpuPend_reg && !busToDma) begin
                cnt_reg <= cnt_reg + 3'h1;
                if (cnt_reg == 3'h2) begin
                    cpuAccessDone <= 1'b1;
                    cpuPend_reg <= 1'b0;
                    cnt_reg <= 3'h0;
                end
            end
        end
    end
endmodule // dmarq_bus_model

// file: tb/test_dmarq_arbiter.sv
// Self-checking bench for the DMA request arbiter
`timescale 1ns/1ps
`include "dmarq_regs.svh"
module test_dmarq_arbiter;
    logic core_clk = 1'b0, rstn = 1'b0, bclkFall, unitDone, cpuAccessDone, busToDma;
    logic prevBus_reg = 1'b0;
    logic [31:0] periphIrq = '0, s_axi_wdata = '0, s_axi_rdata, rv;
    logic [3:0] externalRequestPin = '0, s_axi_wstrb = '0, xferGrant, gLog[$];
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int n_fail = 0, n_tests = 0;
    dmarq_arbiter dmarq_arbiter_i (.core_clk(core_clk), .rstn(rstn), .bclkFall(bclkFall),
        .periphIrq(periphIrq), .externalRequestPin(externalRequestPin), .xferGrant(xferGrant),
        .busToDma(busToDma), .unitDone(unitDone), .cpuAccessDone(cpuAccessDone),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    dmarq_bus_model dmarq_bus_model_i (.core_clk(core_clk), .rstn(rstn), .busToDma(busToDma),
        .bclkFall(bclkFall), .unitDone(unitDone), .cpuAccessDone(cpuAccessDone));
    initial begin
        forever #4 core_clk = !core_clk;
    end
    // Log the winner at every start of a unit
    always @(posedge core_clk) begin
        if (busToDma && !prevBus_reg) gLog.push_back(xferGrant);
        prevBus_reg <= busToDma;
    end
    // ==========================================================
    // Bus tasks, entered just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // An edge passes so a following call never re-raises bready in this time step
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Grant order packed one nibble per unit, oldest first
    function automatic logic [31:0] grants();
        logic [31:0] g;
        g = '0;
        foreach (gLog[i]) g = {g[27:0], gLog[i]};
        gLog.delete();
        return g;
    endfunction
    task automatic irq(input logic [31:0] v, input int w);
        periphIrq <= v;
        repeat (4) @(posedge core_clk);
        periphIrq <= '0;
        repeat (w) @(posedge core_clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(`DMARQ_MODE_OFS);
        chk("mode reset", `DMARQ_MODE_RST, rv);
        rd(`DMARQ_SEL0_OFS);
        chk("select reset", `DMARQ_SEL_RST, rv);
        rd(8'h40);
        chk("unmapped resp", `DMARQ_RESP_SLVERR, resp);
        wr(`DMARQ_STAT_OFS, 32'h0);
        chk("status write resp", `DMARQ_RESP_SLVERR, resp);
        wr(`DMARQ_SEL0_OFS, 32'h81);
        chk("select write resp", `DMARQ_RESP_OKAY, resp);
        irq(32'h2, 20);
        rd(`DMARQ_SEL0_OFS);
        chk("disabled flag", 32'h01, rv);
        chk("disabled grants", 32'h0, grants());
        wr(`DMARQ_CNTZ_OFS, 32'h0);
        wr(`DMARQ_SEL1_OFS, 32'h82);
        wr(`DMARQ_SEL2_OFS, 32'h80);
        wr(`DMARQ_SEL3_OFS, 32'hA0);
        repeat (30) @(posedge core_clk);
        wr(`DMARQ_MODE_OFS, 32'h57);
        irq(32'h6, 40);
        chk("same period order", 32'h12, grants());
        externalRequestPin <= 4'hC;
        repeat (40) @(posedge core_clk);
        chk("rising pin", 32'h8, grants());
        externalRequestPin <= 4'h0;
        repeat (40) @(posedge core_clk);
        chk("falling pin", 32'h48, grants());
        wr(`DMARQ_SEL1_OFS, 32'hC2);
        repeat (30) @(posedge core_clk);
        chk("software trigger", 32'h2, grants());
        // Channel 0 in reserved mode 10 must neither hold the flag nor transfer
        wr(`DMARQ_MODE_OFS, 32'h56);
        irq(32'h2, 20);
        rd(`DMARQ_SEL0_OFS);
        chk("reserved mode flag", 32'h01, rv);
        chk("reserved mode grants", 32'h0, grants());
        wr(`DMARQ_MODE_OFS, 32'h57);
        wr(`DMARQ_CNTZ_OFS, 32'h1);
        irq(32'h2, 20);
        rd(`DMARQ_SEL0_OFS);
        chk("zero count flag", 32'h01, rv);
        chk("zero count grants", 32'h0, grants());
        wr(`DMARQ_MODE_OFS, 32'h0, 4'h0);
        chk("masked write resp", `DMARQ_RESP_OKAY, resp);
        rd(`DMARQ_MODE_OFS);
        chk("masked write", 32'h57, rv);
        wr(`DMARQ_MODE_OFS, 32'h0);
        rd(`DMARQ_STAT_OFS);
        chk("final status", 32'h0, rv & 32'h1FF);
        end_sim();
    end
endmodule // test_dmarq_arbiter
